// ### common/irc_pkg.sv
// package: constants for the interrupt and reset control block
package irc_pkg;
	// vector pair base addresses
	localparam logic [15:0] VEC_RESET = 16'h3FFE;
	localparam logic [15:0] VEC_TRAP = 16'h3FFC;
	localparam logic [15:0] VEC_EXT = 16'h3FFA;
	localparam logic [15:0] VEC_TIMER = 16'h3FF8;
	localparam logic [15:0] VEC_ASYNC = 16'h3FF6;
	localparam logic [15:0] VEC_SYNC = 16'h3FF4;
	// option register addresses (reference only, bits arrive as ports)
	localparam logic [15:0] OPTION_REG_ADDR = 16'h3FDF;
	localparam logic [15:0] MASK_OPTION_REG_ADDR = 16'h3FF1;
	// power-up stabilisation delay in processor cycles
	localparam int POR_DELAY_CYC = 4064;
	// reset pin low time: one and a half machine cycles, in ns, at 10 ns clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_LOW_NS = 15;
	localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// stack bytes per entry
	localparam logic [2:0] IRQ_STACK_BYTES = 3'h5;
	localparam logic [2:0] CALL_STACK_BYTES = 3'h2;
	// selected service source
	typedef enum logic [2:0] {
		IRC_SRC_NONE,
		IRC_SRC_EXT,
		IRC_SRC_TIMER,
		IRC_SRC_ASYNC,
		IRC_SRC_SYNC,
		IRC_SRC_TRAP
	} irc_src_type;
endpackage

// ### design/irc_reset_seq.sv
// module: reset sequencer with power-up delay and reset pin handling
module irc_reset_seq (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic sw_option_mode_i,
	input wire logic reset_pin_i,
	input wire logic watchdog_reset_i,
	input wire logic clock_monitor_reset_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_n_o,
	output logic core_reset_o,
	output logic reset_start_o
);
	// power-up delay counter and pin filter
	logic [11:0] por_cnt_r, por_cnt_nxt;
	logic por_busy_r, por_busy_nxt;
	logic [1:0] low_cnt_r, low_cnt_nxt;
	logic hold_r, hold_nxt;
	logic start_r, start_nxt;
	logic int_drive;

	// next-state logic
	always_comb begin
		por_cnt_nxt = por_cnt_r;
		por_busy_nxt = por_busy_r;
		low_cnt_nxt = low_cnt_r;
		hold_nxt = hold_r;
		start_nxt = 1'b0;
		// count out the stabilisation delay
		if (por_busy_r) begin
			if (por_cnt_r == 12'(irc_pkg::POR_DELAY_CYC - 1)) begin
				por_busy_nxt = 1'b0;
				// keep holding so the release below still raises the start pulse
				hold_nxt = hold_r || !reset_pin_i;
			end else begin
				por_cnt_nxt = por_cnt_r + 12'h001;
			end
		end
		// pin low long enough resets the device
		if (!reset_pin_i) begin
			if (low_cnt_r != 2'(irc_pkg::RESET_LOW_CYC))
				low_cnt_nxt = low_cnt_r + 2'h1;
			else
				hold_nxt = 1'b1;
		end else begin
			low_cnt_nxt = 2'h0;
			// rising pin edge releases at the next clock edge
			if (hold_r && !por_busy_r && !int_drive) begin
				hold_nxt = 1'b0;
				start_nxt = 1'b1;
			end
		end
		if (watchdog_reset_i || clock_monitor_reset_i)
			hold_nxt = 1'b1;
	end

	// internal reset sources drive the pin in software-option mode
	assign int_drive = por_busy_r || watchdog_reset_i || clock_monitor_reset_i;

	// registers; power-up modelled by sys_rst_i
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			por_cnt_r <= 12'h000;
			por_busy_r <= 1'b1;
			low_cnt_r <= 2'h0;
			hold_r <= 1'b1;
			start_r <= 1'b0;
		end else begin
			por_cnt_r <= por_cnt_nxt;
			por_busy_r <= por_busy_nxt;
			low_cnt_r <= low_cnt_nxt;
			hold_r <= hold_nxt;
			start_r <= start_nxt;
		end
	end

	// mask-option mode keeps the pin input-only
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_n_o = !(sw_option_mode_i && int_drive);
	assign core_reset_o = hold_r || por_busy_r || watchdog_reset_i || clock_monitor_reset_i;
	assign reset_start_o = start_r;
endmodule

// ### design/irc_top.sv
// module: interrupt prioritisation and reset control top level
// Functional notes
// - entry stacks registers and sets mask
// - interrupts wait for instruction end, gated
// - fixed priority: reset, external, timer, async, sync
// - trap ignores mask, vector at 3FFC
// - any reset aborts and vectors 3FFE
// - falling edge latched, vector 3FFA
// - pulled-up port B pins act as external
// - trigger sensitivity selected per configuration
// - external latch clears early in service
// - timer flags with enables vector 3FF8
// - async five flags, three enables, 3FF6
// - sync two flags, one enable, 3FF4
// - hold reset 4064 cycles, drive pin in software mode
// - pin low after delay keeps reset
// - pin low 1.5 cycles resets device; the filter needs the pin low at three successive clock edges
// - internal resets drive pin in software mode
// - sequence starts after pin rising edge
// - masked requests stay latched until unmasked
// - interrupt uses five stack bytes
module irc_top (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic sw_option_mode_i, // high: software-option configuration
	input wire logic option_edge_level_i, // option register trigger bit
	input wire logic mask_option_trigger_select_i, // mask option trigger bit
	input wire logic ext_irq_pin_i, // active-low interrupt pin
	input wire logic [7:0] port_b_pin_i,
	input wire logic [7:0] port_b_pullup_i,
	input wire logic input_capture_flag_i,
	input wire logic capture_irq_enable_i,
	input wire logic output_compare_flag_i,
	input wire logic compare_irq_enable_i,
	input wire logic timer_overflow_flag_i,
	input wire logic overflow_irq_enable_i,
	input wire logic transmit_empty_flag_i,
	input wire logic transmit_complete_flag_i,
	input wire logic transmit_irq_enable_i,
	input wire logic receive_full_flag_i,
	input wire logic overrun_flag_i,
	input wire logic receive_irq_enable_i,
	input wire logic line_idle_flag_i,
	input wire logic line_quiet_irq_enable_i,
	input wire logic sync_transfer_done_flag_i,
	input wire logic sync_mode_fault_flag_i,
	input wire logic sync_serial_irq_enable_i,
	input wire logic global_mask_i, // mask bit of condition_flags_register
	input wire logic instr_done_i, // pulse: current instruction complete
	input wire logic trap_fetch_i, // pulse: software_trap_instruction fetched
	input wire logic return_from_handler_i, // pulse: return instruction executing
	input wire logic ext_latch_clear_i, // pulse: early in service routine
	input wire logic reset_pin_i,
	input wire logic watchdog_reset_i,
	input wire logic clock_monitor_reset_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_n_o,
	output logic core_reset_o,
	output logic reset_start_o,
	output logic service_o, // pulse: enter service now
	output logic [2:0] service_src_o,
	output logic [15:0] vector_addr_o, // pair base, high byte address
	output logic [15:0] vector_lo_addr_o, // low byte address
	output logic stack_push_o, // level while entry stacking runs
	output logic stack_pull_o, // level while return unstacking runs
	output logic set_global_mask_o, // pulse with entry
	output logic [2:0] stack_bytes_o,
	output logic pin_level_o // level for pin-level branch instructions
);
	// external trigger, latch and sequencing state
	logic ext_q_r, ext_q_nxt;
	logic ext_latch_r, ext_latch_nxt;
	logic trap_pend_r, trap_pend_nxt;
	logic [2:0] src_r, src_nxt;
	logic [15:0] vec_r, vec_nxt;
	logic svc_r, svc_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic push_r, push_nxt;
	logic pull_r, pull_nxt;
	logic [2:0] bytes_r, bytes_nxt;
	logic edge_level;
	logic ext_line;
	logic ext_req, timer_req, async_req, sync_req;
	logic core_rst;

	// vector base for a source
	function automatic logic [15:0] vec_of(input logic [2:0] s);
		case (s)
			3'(irc_pkg::IRC_SRC_EXT): vec_of = irc_pkg::VEC_EXT;
			3'(irc_pkg::IRC_SRC_TIMER): vec_of = irc_pkg::VEC_TIMER;
			3'(irc_pkg::IRC_SRC_ASYNC): vec_of = irc_pkg::VEC_ASYNC;
			3'(irc_pkg::IRC_SRC_SYNC): vec_of = irc_pkg::VEC_SYNC;
			3'(irc_pkg::IRC_SRC_TRAP): vec_of = irc_pkg::VEC_TRAP;
			default: vec_of = irc_pkg::VEC_RESET;
		endcase
	endfunction

	// reset sequencer
	irc_reset_seq u_rst (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.sw_option_mode_i(sw_option_mode_i),
		.reset_pin_i(reset_pin_i),
		.watchdog_reset_i(watchdog_reset_i),
		.clock_monitor_reset_i(clock_monitor_reset_i),
		.reset_pin_o(reset_pin_o),
		.reset_pin_oe_n_o(reset_pin_oe_n_o),
		.core_reset_o(core_rst),
		.reset_start_o(reset_start_o)
	);
	assign core_reset_o = core_rst;

	// sensitivity comes from the configuration in force
	assign edge_level = sw_option_mode_i ? option_edge_level_i : mask_option_trigger_select_i;
	// pulled-up port B pins join the pin as a wired low source
	assign ext_line = ext_irq_pin_i && &(port_b_pin_i | ~port_b_pullup_i);
	assign pin_level_o = ext_line;

	// group requests; flags are only read, never cleared here
	assign timer_req = (input_capture_flag_i && capture_irq_enable_i) ||
		(output_compare_flag_i && compare_irq_enable_i) ||
		(timer_overflow_flag_i && overflow_irq_enable_i);
	assign async_req = ((transmit_empty_flag_i || transmit_complete_flag_i) && transmit_irq_enable_i) ||
		((receive_full_flag_i || overrun_flag_i) && receive_irq_enable_i) ||
		(line_idle_flag_i && line_quiet_irq_enable_i);
	assign sync_req = (sync_transfer_done_flag_i || sync_mode_fault_flag_i) && sync_serial_irq_enable_i;
	// level mode keeps asking while the line stays low
	assign ext_req = ext_latch_r || (edge_level && !ext_line);

	// next-state logic for latch, arbitration and stacking
	always_comb begin
		ext_q_nxt = ext_line;
		ext_latch_nxt = ext_latch_r;
		trap_pend_nxt = trap_pend_r;
		src_nxt = src_r;
		vec_nxt = vec_r;
		svc_nxt = 1'b0;
		cnt_nxt = cnt_r;
		push_nxt = push_r;
		pull_nxt = pull_r;
		bytes_nxt = bytes_r;
		// early clear first so a new edge in the same cycle wins
		if (ext_latch_clear_i)
			ext_latch_nxt = 1'b0;
		if (ext_q_r && !ext_line)
			ext_latch_nxt = 1'b1;
		if (trap_fetch_i)
			trap_pend_nxt = 1'b1;
		// stacking and unstacking count down bytes
		if (cnt_r != 3'h0) begin
			cnt_nxt = cnt_r - 3'h1;
			if (cnt_r == 3'h1) begin
				push_nxt = 1'b0;
				pull_nxt = 1'b0;
			end
		end else if (return_from_handler_i) begin
			cnt_nxt = irc_pkg::IRQ_STACK_BYTES;
			pull_nxt = 1'b1;
			bytes_nxt = irc_pkg::IRQ_STACK_BYTES;
		end else if (instr_done_i) begin
			// arbitration only at instruction boundaries
			src_nxt = 3'(irc_pkg::IRC_SRC_NONE);
			if (!global_mask_i && ext_req)
				src_nxt = 3'(irc_pkg::IRC_SRC_EXT);
			else if (!global_mask_i && timer_req)
				src_nxt = 3'(irc_pkg::IRC_SRC_TIMER);
			else if (!global_mask_i && async_req)
				src_nxt = 3'(irc_pkg::IRC_SRC_ASYNC);
			else if (!global_mask_i && sync_req)
				src_nxt = 3'(irc_pkg::IRC_SRC_SYNC);
			else if (trap_pend_r) begin
				src_nxt = 3'(irc_pkg::IRC_SRC_TRAP);
				trap_pend_nxt = 1'b0;
			end
			if (src_nxt != 3'(irc_pkg::IRC_SRC_NONE)) begin
				svc_nxt = 1'b1;
				vec_nxt = vec_of(src_nxt);
				cnt_nxt = irc_pkg::IRQ_STACK_BYTES;
				push_nxt = 1'b1;
				bytes_nxt = irc_pkg::IRQ_STACK_BYTES;
			end
		end
	end

	// registers; any reset aborts work and points at the reset vector
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || core_rst) begin
			ext_q_r <= 1'b1;
			ext_latch_r <= 1'b0;
			trap_pend_r <= 1'b0;
			src_r <= 3'(irc_pkg::IRC_SRC_NONE);
			vec_r <= irc_pkg::VEC_RESET;
			svc_r <= 1'b0;
			cnt_r <= 3'h0;
			push_r <= 1'b0;
			pull_r <= 1'b0;
			bytes_r <= irc_pkg::CALL_STACK_BYTES;
		end else begin
			ext_q_r <= ext_q_nxt;
			ext_latch_r <= ext_latch_nxt;
			trap_pend_r <= trap_pend_nxt;
			src_r <= src_nxt;
			vec_r <= vec_nxt;
			svc_r <= svc_nxt;
			cnt_r <= cnt_nxt;
			push_r <= push_nxt;
			pull_r <= pull_nxt;
			bytes_r <= bytes_nxt;
		end
	end

	assign service_o = svc_r;
	assign service_src_o = src_r;
	assign vector_addr_o = vec_r;
	assign vector_lo_addr_o = vec_r + 16'h0001;
	assign stack_push_o = push_r;
	assign stack_pull_o = pull_r;
	assign set_global_mask_o = svc_r;
	assign stack_bytes_o = bytes_r;

	// checks
	ext_prio_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		instr_done_i && cnt_r == 3'h0 && !return_from_handler_i && !global_mask_i && ext_req
		|=> service_o && service_src_o == 3'(irc_pkg::IRC_SRC_EXT))
		else $error("external not chosen first");
	mask_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		$rose(service_o) && global_mask_i == $past(global_mask_i) && $past(global_mask_i)
		|-> service_src_o == 3'(irc_pkg::IRC_SRC_TRAP))
		else $error("masked source serviced");
	trap_vec_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		service_o && service_src_o == 3'(irc_pkg::IRC_SRC_TRAP) |-> vector_addr_o == irc_pkg::VEC_TRAP)
		else $error("trap vector wrong");
	timer_vec_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		service_o && service_src_o == 3'(irc_pkg::IRC_SRC_TIMER) |-> vector_addr_o == irc_pkg::VEC_TIMER)
		else $error("timer vector wrong");
	edge_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		$fell(ext_line) ##1 1'b1 |=> ext_latch_r)
		else $error("falling edge not latched");
	push_len_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		$rose(stack_push_o) |-> stack_push_o [*5] ##1 !stack_push_o)
		else $error("stacking not five bytes");
	pull_len_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		$rose(stack_pull_o) |-> stack_pull_o [*5] ##1 !stack_pull_o)
		else $error("unstacking not five bytes");
	mask_set_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || core_rst)
		service_o |-> set_global_mask_o && stack_push_o)
		else $error("entry without mask set");
	lo_addr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		vector_lo_addr_o == vector_addr_o + 16'h0001)
		else $error("vector byte pair broken");
	rst_vec_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		core_rst |=> vector_addr_o == irc_pkg::VEC_RESET && !service_o)
		else $error("reset did not abort");
	ext_svc_c: cover property (@(posedge sys_clk_i) service_o && service_src_o == 3'(irc_pkg::IRC_SRC_EXT));
	trap_svc_c: cover property (@(posedge sys_clk_i) service_o && service_src_o == 3'(irc_pkg::IRC_SRC_TRAP));
	sync_svc_c: cover property (@(posedge sys_clk_i) service_o && service_src_o == 3'(irc_pkg::IRC_SRC_SYNC));
	rst_start_c: cover property (@(posedge sys_clk_i) reset_start_o);
endmodule

// ### sim/irc_core_model.sv
// partner model: core instruction boundaries, service routine start and the reset pin wire
module irc_core_model (
	input wire logic sys_clk_i,
	input wire logic halt_i, // core held in reset or busy stacking
	input wire logic [3:0] gap_i, // idle cycles between boundaries, small is prompt
	input wire logic ext_entry_i, // entry into service for the external source
	input wire logic pin_low_i, // an outside party pulls the reset pin low
	input wire logic pin_oe_n_i, // device pulls the reset pin low when this is low
	output logic instr_done_o,
	output logic ext_latch_clear_o,
	output logic reset_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r = 4'h0; // cycles since the last boundary
	logic [1:0] clr_dly_r = 2'h0; // routine start lags entry by two cycles
	// instructions only finish while the core runs, never in mid-stacking
	always_ff @(posedge sys_clk_i) begin
		if (halt_i) begin
			cnt_r <= 4'h0;
			instr_done_o <= 1'b0;
		end else begin
			instr_done_o <= (cnt_r == gap_i);
			cnt_r <= (cnt_r == gap_i) ? 4'h0 : cnt_r + 4'h1;
		end
		clr_dly_r <= {clr_dly_r[0], ext_entry_i};
	end
	// the routine clears the external latch early on
	assign ext_latch_clear_o = clr_dly_r[1];
	// pulled-up open-drain wire, low if either party drives it
	assign reset_pin_o = !(pin_low_i || !pin_oe_n_i);
endmodule

// ### sim/irc_top_tb.sv
// testbench: interrupt prioritisation and reset control block against the core model
module irc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, sw_option_mode_i = 1'b1, option_edge_level_i = 1'b0;
	logic mask_option_trigger_select_i = 1'b0, ext_irq_pin_i = 1'b1, global_mask_i = 1'b0, trap_fetch_i = 1'b0;
	logic return_from_handler_i = 1'b0, watchdog_reset_i = 1'b0, clock_monitor_reset_i = 1'b0, pin_low = 1'b1;
	logic [7:0] port_b_pin_i = 8'hFF, port_b_pullup_i = 8'h00;
	logic [16:0] per = 17'h0_0000; // peripheral flags and enables, one bit each
	logic [3:0] gap = 4'h6; // slow core keeps level requests from racing the latch clear
	logic instr_done_i, ext_latch_clear_i, reset_pin_i, reset_pin_o, reset_pin_oe_n_o, core_reset_o;
	logic reset_start_o, service_o, stack_push_o, stack_pull_o, set_global_mask_o, pin_level_o;
	logic [2:0] service_src_o, stack_bytes_o;
	logic [15:0] vector_addr_o, vector_lo_addr_o;
	int miscompares = 0;
	int checks_done = 0;
	irc_top DUT (.sys_clk_i, .sys_rst_i, .sw_option_mode_i, .option_edge_level_i, .mask_option_trigger_select_i,
		.ext_irq_pin_i, .port_b_pin_i, .port_b_pullup_i, .input_capture_flag_i(per[0]), .capture_irq_enable_i(per[1]),
		.output_compare_flag_i(per[2]), .compare_irq_enable_i(per[3]), .timer_overflow_flag_i(per[4]),
		.overflow_irq_enable_i(per[5]), .transmit_empty_flag_i(per[6]), .transmit_complete_flag_i(per[7]),
		.transmit_irq_enable_i(per[8]), .receive_full_flag_i(per[9]), .overrun_flag_i(per[10]),
		.receive_irq_enable_i(per[11]), .line_idle_flag_i(per[12]), .line_quiet_irq_enable_i(per[13]),
		.sync_transfer_done_flag_i(per[14]), .sync_mode_fault_flag_i(per[15]), .sync_serial_irq_enable_i(per[16]),
		.global_mask_i, .instr_done_i, .trap_fetch_i, .return_from_handler_i, .ext_latch_clear_i, .reset_pin_i,
		.watchdog_reset_i, .clock_monitor_reset_i, .reset_pin_o, .reset_pin_oe_n_o, .core_reset_o, .reset_start_o,
		.service_o, .service_src_o, .vector_addr_o, .vector_lo_addr_o, .stack_push_o, .stack_pull_o,
		.set_global_mask_o, .stack_bytes_o, .pin_level_o);
	irc_core_model core (.sys_clk_i, .halt_i(core_reset_o || stack_push_o || stack_pull_o), .gap_i(gap),
		.ext_entry_i(service_o && service_src_o == irc_pkg::IRC_SRC_EXT), .pin_low_i(pin_low),
		.pin_oe_n_i(reset_pin_oe_n_o), .instr_done_o(instr_done_i), .ext_latch_clear_o(ext_latch_clear_i),
		.reset_pin_o(reset_pin_i));
	always #5 sys_clk_i = ~sys_clk_i;
	// compare and count
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chkb(input string what, input logic seen, input logic exp);
		chk(what, {15'h0, seen}, {15'h0, exp});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic logic [15:0] vec(input irc_pkg::irc_src_type s);
		case (s)
			irc_pkg::IRC_SRC_EXT: return irc_pkg::VEC_EXT;
			irc_pkg::IRC_SRC_TIMER: return irc_pkg::VEC_TIMER;
			irc_pkg::IRC_SRC_ASYNC: return irc_pkg::VEC_ASYNC;
			irc_pkg::IRC_SRC_SYNC: return irc_pkg::VEC_SYNC;
			default: return irc_pkg::VEC_TRAP;
		endcase
	endfunction
	// wait boundedly for one entry, judge it, then drop the serviced flags
	task automatic wait_svc(input irc_pkg::irc_src_type s, input logic [16:0] clr);
		int n;
		n = 0;
		while (service_o !== 1'b1 && n < 60) begin
			@(negedge sys_clk_i);
			n++;
		end
		chkb("service", service_o, 1'b1);
		chk("source", {13'h0, service_src_o}, {13'h0, s});
		chk("vector", vector_addr_o, vec(s));
		chk("vector low", vector_lo_addr_o, vec(s) + 16'h0001);
		chkb("mask set", set_global_mask_o, 1'b1);
		n = 0;
		while (stack_push_o === 1'b1 && n < 9) begin
			n++;
			@(negedge sys_clk_i);
		end
		chk("push cycles", n[15:0], 16'h0005);
		chk("stack bytes", {13'h0, stack_bytes_o}, {13'h0, irc_pkg::IRQ_STACK_BYTES});
		@(posedge sys_clk_i);
		per <= per & ~clr;
	endtask
	task automatic no_svc(input int n);
		int hits;
		hits = 0;
		repeat (n) begin
			@(negedge sys_clk_i);
			if (service_o === 1'b1) hits++;
		end
		chk("stray service", hits[15:0], 16'h0000);
	endtask
	task automatic wait_start(input int bound, output int n);
		n = 0;
		while (reset_start_o !== 1'b1 && n < bound) begin
			@(negedge sys_clk_i);
			n++;
		end
		chkb("reset start", reset_start_o, 1'b1);
		chkb("core released", core_reset_o, 1'b0);
	endtask
	// power-up in software mode with the pin held low from outside
	task automatic t_power();
		int n;
		repeat (5) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chkb("core reset", core_reset_o, 1'b1);
		chkb("pin driven", reset_pin_oe_n_o, 1'b0);
		chk("reset vector", vector_addr_o, irc_pkg::VEC_RESET);
		chkb("pin value", reset_pin_o, 1'b0);
		chk("reset stack bytes", {13'h0, stack_bytes_o}, {13'h0, irc_pkg::CALL_STACK_BYTES});
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		repeat (4100) @(negedge sys_clk_i);
		chkb("held by pin", core_reset_o, 1'b1);
		@(posedge sys_clk_i);
		pin_low <= 1'b0;
		wait_start(8, n);
		$display("power-up test done");
	endtask
	// every flag alone is ignored, with its own enable it vectors to its group
	task automatic t_groups();
		int f[10] = '{6, 7, 9, 10, 12, 0, 2, 4, 14, 15};
		int e[10] = '{8, 8, 11, 11, 13, 1, 3, 5, 16, 16};
		gap <= 4'h2;
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk_i);
			per <= 17'(17'h0_0001 << f[i]);
			no_svc(12);
			@(posedge sys_clk_i);
			per[e[i]] <= 1'b1;
			wait_svc(i < 5 ? irc_pkg::IRC_SRC_ASYNC : (i < 8 ? irc_pkg::IRC_SRC_TIMER : irc_pkg::IRC_SRC_SYNC),
				17'h1_FFFF);
		end
		gap <= 4'h6;
		$display("group test done");
	endtask
	// all groups pending under the mask, then released in one go
	task automatic t_priority();
		@(posedge sys_clk_i);
		global_mask_i <= 1'b1;
		per <= 17'h1_4143;
		ext_irq_pin_i <= 1'b0;
		no_svc(20);
		@(posedge sys_clk_i);
		global_mask_i <= 1'b0;
		wait_svc(irc_pkg::IRC_SRC_EXT, 17'h0_0000);
		ext_irq_pin_i <= 1'b1;
		wait_svc(irc_pkg::IRC_SRC_TIMER, 17'h0_0003);
		wait_svc(irc_pkg::IRC_SRC_ASYNC, 17'h0_0140);
		wait_svc(irc_pkg::IRC_SRC_SYNC, 17'h1_4000);
		no_svc(20);
		$display("priority test done");
	endtask
	// trap after a pending request, trap under the mask, then return unstacking
	task automatic t_trap();
		int n;
		@(posedge sys_clk_i);
		per <= 17'h0_0030;
		trap_fetch_i <= 1'b1;
		@(posedge sys_clk_i);
		trap_fetch_i <= 1'b0;
		wait_svc(irc_pkg::IRC_SRC_TIMER, 17'h0_0030);
		wait_svc(irc_pkg::IRC_SRC_TRAP, 17'h0_0000);
		global_mask_i <= 1'b1;
		trap_fetch_i <= 1'b1;
		@(posedge sys_clk_i);
		trap_fetch_i <= 1'b0;
		wait_svc(irc_pkg::IRC_SRC_TRAP, 17'h0_0000);
		global_mask_i <= 1'b0;
		return_from_handler_i <= 1'b1;
		@(posedge sys_clk_i);
		return_from_handler_i <= 1'b0;
		n = 0;
		@(negedge sys_clk_i);
		while (stack_pull_o === 1'b1 && n < 9) begin
			n++;
			@(negedge sys_clk_i);
		end
		chk("pull cycles", n[15:0], 16'h0005);
		$display("trap test done");
	endtask
	// edge and level triggers in software mode, level trigger in mask-option mode, and port B pins
	task automatic t_ext();
		@(posedge sys_clk_i);
		ext_irq_pin_i <= 1'b0;
		wait_svc(irc_pkg::IRC_SRC_EXT, 17'h0_0000);
		no_svc(25);
		@(posedge sys_clk_i);
		option_edge_level_i <= 1'b1;
		wait_svc(irc_pkg::IRC_SRC_EXT, 17'h0_0000);
		option_edge_level_i <= 1'b0;
		sw_option_mode_i <= 1'b0;
		mask_option_trigger_select_i <= 1'b1;
		wait_svc(irc_pkg::IRC_SRC_EXT, 17'h0_0000);
		ext_irq_pin_i <= 1'b1;
		sw_option_mode_i <= 1'b1;
		mask_option_trigger_select_i <= 1'b0;
		no_svc(25);
		@(posedge sys_clk_i);
		port_b_pullup_i <= 8'h08;
		port_b_pin_i <= 8'hF7;
		@(negedge sys_clk_i);
		chkb("pin level", pin_level_o, 1'b0);
		wait_svc(irc_pkg::IRC_SRC_EXT, 17'h0_0000);
		port_b_pin_i <= 8'hDF;
		no_svc(25);
		chkb("pin level", pin_level_o, 1'b1);
		@(posedge sys_clk_i);
		port_b_pin_i <= 8'hFF;
		$display("external test done");
	endtask
	// pin pulse, watchdog and clock monitor, then a mask-option power-up
	task automatic t_resets();
		int n;
		@(posedge sys_clk_i);
		pin_low <= 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chkb("pin reset", core_reset_o, 1'b1);
		@(posedge sys_clk_i);
		pin_low <= 1'b0;
		wait_start(8, n);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk_i);
			{clock_monitor_reset_i, watchdog_reset_i} <= 2'b01 << k;
			repeat (3) @(negedge sys_clk_i);
			chkb("pin driven", reset_pin_oe_n_o, 1'b0);
			chkb("core reset", core_reset_o, 1'b1);
			chk("reset vector", vector_addr_o, irc_pkg::VEC_RESET);
			@(posedge sys_clk_i);
			{clock_monitor_reset_i, watchdog_reset_i} <= 2'b00;
			wait_start(5000, n);
		end
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		sw_option_mode_i <= 1'b0;
		repeat (3) @(negedge sys_clk_i);
		chkb("input only", reset_pin_oe_n_o, 1'b1);
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		wait_start(4200, n);
		chkb("delay length", n >= 4064 && n <= 4068, 1'b1);
		$display("reset test done");
	endtask
	initial begin
		t_power();
		t_groups();
		t_priority();
		t_trap();
		t_ext();
		t_resets();
		stop_test();
	end
	// hang guard, about four and a half times the expected run
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		miscompares++;
		stop_test();
	end
endmodule
